// ===== inc/ebt_pkg.sv
// constants shared by the eight-bit timer/counter design
package ebt_pkg;

   // register bus geometry
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;

   // register offsets (byte addresses on the plain port)
   localparam logic [ADDR_W-1:0] OFS_COUNT   = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_STATUS  = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_MASK    = 4'h3;

   // control register field positions
   localparam int unsigned CTL_RATE_LSB   = 0;
   localparam int unsigned CTL_RATE_W     = 3;
   localparam int unsigned CTL_BYPASS_BIT = 3;
   localparam int unsigned CTL_EDGE_BIT   = 4;
   localparam int unsigned CTL_SRC_BIT    = 5;
   localparam int unsigned CTL_W          = 6;

   // status and mask field positions
   localparam int unsigned STS_OVF_BIT = 0;
   localparam int unsigned STS_W       = 1;

   // reset values
   localparam logic [DATA_W-1:0] RST_COUNT   = 8'h00;
   localparam logic [CTL_W-1:0]  RST_CONTROL = 6'h3F;
   localparam logic [STS_W-1:0]  RST_STATUS  = 1'h0;
   localparam logic [STS_W-1:0]  RST_MASK    = 1'h0;

   // count register maximum and increment step
   localparam logic [DATA_W-1:0] COUNT_MAX = 8'hFF;
   localparam logic [DATA_W-1:0] COUNT_ONE = 8'h01;

   // prescaler width and increment hold-off after a count write
   localparam int unsigned PRE_W        = 8;
   localparam int unsigned HOLD_CYCLES  = 2;
   localparam int unsigned HOLD_W       = 2;

endpackage : ebt_pkg

// ===== src/ebt_timer.sv
// eight-bit timer/counter with prescaler, overflow interrupt and gate output
//
// Behaviour
// RQ1: an 8-bit count register is readable and writable and works as a timer or a counter.
// RQ2: in timer mode with the prescaler bypassed the count advances every instruction cycle.
// RQ3: with count_source_select cleared the source is the instruction-cycle clock.
// RQ4: a write to the count register holds off incrementing for the next two cycles.
// RQ5: software may preload an offset value to make up for the two-cycle hold-off.
// RQ6: with count_source_select set the count advances once per qualifying external edge.
// RQ7: in counter mode source_edge_select picks rising or falling external edges.
// RQ8: the timer owns a private 8-bit prescaler not shared with any watchdog.
// RQ9: a signal derived from this timer is offered as a gate source to the companion timer.
// RQ10: prescaler_bypass cleared inserts a 1:2 to 1:256 prescaler, set gives 1:1.
// RQ11: a count register write clears the prescaler, which is neither readable nor writable.
// RQ12: every FFh to 00h wrap sets overflow_flag regardless of enable; only software clears it.
// RQ13: the external edge is synchronised to the instruction clock before it advances the count.
// RQ14: source_edge_select set counts falling transitions, cleared counts rising transitions.

`timescale 1ns/1ns
`default_nettype none

module ebt_timer #(
   parameter int unsigned PRE_W = ebt_pkg::PRE_W
) (
   input  wire logic                      clk_i,
   input  wire logic                      rst_n_i,
   input  wire logic [ebt_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [ebt_pkg::DATA_W-1:0] wdata_i,
   input  wire logic                      wr_i,
   input  wire logic                      rd_i,
   output logic      [ebt_pkg::DATA_W-1:0] rdata_o,
   input  wire logic                      external_count_input_i,
   output logic      [ebt_pkg::DATA_W-1:0] count_o,
   output logic                           gate_source_o,
   output logic                           irq_o
);

   // register storage
   logic [ebt_pkg::DATA_W-1:0] count_register_q;
   logic [ebt_pkg::DATA_W-1:0] count_register_d;
   logic [ebt_pkg::CTL_W-1:0]  control_q;
   logic [ebt_pkg::STS_W-1:0]  status_q;
   logic [ebt_pkg::STS_W-1:0]  mask_q;
   logic [ebt_pkg::DATA_W-1:0] rdata_q;
   logic                       rd_valid_q;

   // control fields
   logic                          count_source_select;
   logic                          source_edge_select;
   logic                          prescaler_bypass;
   logic [ebt_pkg::CTL_RATE_W-1:0] prescale_rate_select;

   // bus decode
   logic wr_count;
   logic wr_control;
   logic wr_status;
   logic wr_mask;

   // external input path
   logic ext_meta_q;
   logic ext_sync_q;
   logic ext_prev_q;
   logic ext_rise;
   logic ext_fall;
   logic ext_edge;

   // prescaler and increment path
   logic [PRE_W-1:0]          pre_q;
   logic [PRE_W-1:0]          pre_mask;
   logic                      src_tick;
   logic                      pre_tick;
   logic                      inc_tick;
   logic [ebt_pkg::HOLD_W-1:0] hold_q;
   logic                      wrap;
   logic                      gate_q;

   assign count_source_select  = control_q[ebt_pkg::CTL_SRC_BIT];
   assign source_edge_select   = control_q[ebt_pkg::CTL_EDGE_BIT];
   assign prescaler_bypass     = control_q[ebt_pkg::CTL_BYPASS_BIT];
   assign prescale_rate_select =
      control_q[ebt_pkg::CTL_RATE_LSB +: ebt_pkg::CTL_RATE_W];

   assign wr_count   = wr_i && (addr_i == ebt_pkg::OFS_COUNT);
   assign wr_control = wr_i && (addr_i == ebt_pkg::OFS_CONTROL);
   assign wr_status  = wr_i && (addr_i == ebt_pkg::OFS_STATUS);
   assign wr_mask    = wr_i && (addr_i == ebt_pkg::OFS_MASK);

   // two-stage synchroniser; only the second stage is looked at
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ext_meta_q <= 1'b0;
         ext_sync_q <= 1'b0;
      end
      else
      begin
         ext_meta_q <= external_count_input_i;
         ext_sync_q <= ext_meta_q; // RQ13
      end
   end

   // previous synchronised level; resets to the synchroniser's own reset
   // level so that no false edge follows reset
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ext_prev_q <= 1'b0;
      end
      else
      begin
         ext_prev_q <= ext_sync_q;
      end
   end

   // both edges come from the synchronised level, so a change of source_edge_select
   // cannot invent an edge
   assign ext_rise = ext_sync_q && !ext_prev_q;
   assign ext_fall = !ext_sync_q && ext_prev_q;

   always_comb
   begin
      if (source_edge_select)
      begin
         ext_edge = ext_fall; // RQ7 RQ14
      end
      else
      begin
         ext_edge = ext_rise; // RQ7 RQ14
      end
   end

   // source of counting events
   always_comb
   begin
      if (count_source_select)
      begin
         src_tick = ext_edge; // RQ6
      end
      else
      begin
         src_tick = 1'b1; // RQ3
      end
   end

   // ratio 2^(rate+1): tick when the low rate+1 prescaler bits are all ones
   for (genvar gi = 0; gi < PRE_W; gi++)
   begin : g_pre_mask
      assign pre_mask[gi] = (gi <= int'(prescale_rate_select));
   end

   // private prescaler, cleared by any count write and never visible on the bus
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pre_q <= '0;
      end
      else if (wr_count)
      begin
         pre_q <= '0; // RQ11
      end
      else if (src_tick && !prescaler_bypass)
      begin
         pre_q <= pre_q + 1'b1; // RQ8
      end
   end

   always_comb
   begin
      if (prescaler_bypass)
      begin
         pre_tick = src_tick; // RQ10
      end
      else
      begin
         pre_tick = src_tick && ((pre_q & pre_mask) == pre_mask); // RQ10
      end
   end

   // increment hold-off after a count write; ticks inside the window are lost
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         hold_q <= '0;
      end
      else if (wr_count)
      begin
         hold_q <= ebt_pkg::HOLD_W'(ebt_pkg::HOLD_CYCLES); // RQ4
      end
      else if (hold_q != '0)
      begin
         hold_q <= hold_q - 1'b1;
      end
   end

   always_comb
   begin
      inc_tick = 1'b0;
      if (pre_tick && (hold_q == '0) && !wr_count)
      begin
         inc_tick = 1'b1; // RQ4
      end
   end

   // a wrap is an increment taken while the count stands at its maximum
   always_comb
   begin
      wrap = 1'b0;
      if (inc_tick && (count_register_q == ebt_pkg::COUNT_MAX))
      begin
         wrap = 1'b1; // RQ12
      end
   end

   // count register: a bus write wins over an increment in the same cycle
   always_comb
   begin
      count_register_d = count_register_q;
      if (wr_count)
      begin
         count_register_d = wdata_i; // RQ1
      end
      else if (inc_tick)
      begin
         count_register_d = count_register_q + ebt_pkg::COUNT_ONE; // RQ2
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         count_register_q <= ebt_pkg::RST_COUNT;
      end
      else
      begin
         count_register_q <= count_register_d; // RQ1
      end
   end

   // control register
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         control_q <= ebt_pkg::RST_CONTROL;
      end
      else if (wr_control)
      begin
         control_q <= wdata_i[ebt_pkg::CTL_W-1:0];
      end
   end

   // overflow flag: sticky, write one to clear, a new wrap beats the clear
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         status_q <= ebt_pkg::RST_STATUS;
      end
      else if (wrap)
      begin
         status_q[ebt_pkg::STS_OVF_BIT] <= 1'b1; // RQ12
      end
      else if (wr_status && wdata_i[ebt_pkg::STS_OVF_BIT])
      begin
         status_q[ebt_pkg::STS_OVF_BIT] <= 1'b0; // RQ12
      end
   end

   // overflow interrupt enable
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         mask_q <= ebt_pkg::RST_MASK;
      end
      else if (wr_mask)
      begin
         mask_q <= wdata_i[ebt_pkg::STS_W-1:0];
      end
   end

   // gate source: one-cycle pulse per wrap, registered for the companion timer
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         gate_q <= 1'b0;
      end
      else
      begin
         gate_q <= wrap; // RQ9
      end
   end

   // delayed read strobe marks the only cycle in which read data stand
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rd_valid_q <= 1'b0;
      end
      else
      begin
         rd_valid_q <= rd_i;
      end
   end

   // read data: unmapped addresses and idle cycles give zero
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rdata_q <= '0;
      end
      else if (rd_i)
      begin
         unique case (addr_i)
            ebt_pkg::OFS_COUNT:   rdata_q <= count_register_q; // RQ1
            ebt_pkg::OFS_CONTROL: rdata_q <= ebt_pkg::DATA_W'(control_q);
            ebt_pkg::OFS_STATUS:  rdata_q <= ebt_pkg::DATA_W'(status_q);
            ebt_pkg::OFS_MASK:    rdata_q <= ebt_pkg::DATA_W'(mask_q);
            default:              rdata_q <= '0;
         endcase
      end
      else
      begin
         rdata_q <= '0;
      end
   end

   assign rdata_o       = rd_valid_q ? rdata_q : '0;
   assign count_o       = count_register_q;
   assign gate_source_o = gate_q;
   // plain level: it follows the sticky flag and its enable, no edge memory
   assign irq_o         = |(status_q & mask_q);

endmodule : ebt_timer

`default_nettype wire

// ===== dv/ebt_timer_asserts.sv
// assertion checker on the eight-bit timer ports
`timescale 1ns/1ns
`default_nettype none
module ebt_timer_asserts #(
   parameter int unsigned PRE_W = 8
) (
   input wire logic       clk_i,
   input wire logic       rst_n_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic       wr_i,
   input wire logic       rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic [7:0] count_o,
   input wire logic       gate_source_o,
   input wire logic       irq_o
);
   logic wc;
   logic rc;
   assign wc = wr_i && addr_i == ebt_pkg::OFS_COUNT;
   assign rc = rd_i && addr_i == ebt_pkg::OFS_COUNT;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // a wrap is only seen as ffh then 00h with no count write between
   sequence s_wrap;
      count_o == ebt_pkg::COUNT_MAX && !wc ##1 count_o == 8'h00;
   endsequence
   property p_wr; wc |=> count_o == $past(wdata_i); endproperty
   a_wr: assert property (p_wr) else $error("count write lost");
   property p_rd; rc |=> rdata_o == $past(count_o); endproperty
   a_rd: assert property (p_rd) else $error("count read wrong");
   property p_rz; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
   a_rz: assert property (p_rz) else $error("read data not idle");
   property p_hold; wc ##1 !wc [*2] |=> count_o == $past(wdata_i, 3); endproperty
   a_hold: assert property (p_hold) else $error("count moved in hold-off");
   property p_gate; s_wrap |-> ##[0:1] gate_source_o; endproperty
   a_gate: assert property (p_gate) else $error("no gate pulse on wrap");
   property p_pulse; gate_source_o |=> !gate_source_o; endproperty
   a_pulse: assert property (p_pulse) else $error("gate pulse too long");
   property p_gcause; gate_source_o |-> count_o == 8'h00 || $past(count_o) == 8'h00; endproperty
   a_gcause: assert property (p_gcause) else $error("gate pulse without wrap");
   property p_fell; $fell(irq_o) |-> $past(wr_i); endproperty
   a_fell: assert property (p_fell) else $error("flag cleared by itself");
endmodule : ebt_timer_asserts
bind ebt_timer ebt_timer_asserts #(.PRE_W(PRE_W)) u_ebt_timer_asserts (
   .clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .count_o,
   .gate_source_o, .irq_o
);
`default_nettype wire

// ===== dv/ebt_pulse_src.sv
// external pulse source driving the count pin
`timescale 1ns/1ns
`default_nettype none
module ebt_pulse_src (
   input  wire logic       clk_i,
   input  wire logic [5:0] n_i,
   input  wire logic [2:0] gap_i,
   input  wire logic       go_i,
   output logic            pin_o,
   output logic            busy_o
);
   initial
   begin
      pin_o = 1'b0;
      busy_o = 1'b0;
   end
   // n_i toggles; each level stands 3 cycles or more so the synchroniser sees it
   always @(posedge clk_i)
      if (go_i && !busy_o)
      begin
         busy_o <= 1'b1;
         repeat (n_i)
         begin
            repeat (gap_i + 3) @(posedge clk_i);
            pin_o <= ~pin_o;
         end
         busy_o <= 1'b0;
      end
endmodule : ebt_pulse_src
`default_nettype wire

// ===== dv/ebt_timer_test.sv
// self-checking bench for the eight-bit timer/counter
`timescale 1ns/1ns
`default_nettype none
module ebt_timer_test;
   localparam logic [3:0] CNT = ebt_pkg::OFS_COUNT, CTL = ebt_pkg::OFS_CONTROL;
   localparam logic [3:0] STS = ebt_pkg::OFS_STATUS, MSK = ebt_pkg::OFS_MASK;
   logic       clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, go = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00, rdata_o, count_o, d;
   logic [5:0] n = 6'h01;
   logic [2:0] gap = 3'h0;
   logic       gate_source_o, irq_o, ext, busy;
   int         m, failures = 0, total_checks = 0;
   ebt_timer u_ebt_timer (
      .clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .external_count_input_i(ext), .count_o, .gate_source_o, .irq_o
   );
   ebt_pulse_src u_ebt_pulse_src (
      .clk_i, .n_i(n), .gap_i(gap), .go_i(go), .pin_o(ext), .busy_o(busy)
   );
   initial
   begin
      forever #2 clk_i = ~clk_i;
   end
   task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", w, e, g);
      end
   endtask : chk
   task automatic final_report();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : final_report
   task automatic tick(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask : tick
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rdchk(input logic [3:0] a, input string w, input logic [7:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(w, e, rdata_o);
   endtask : rdchk
   task automatic pulse();
      @(posedge clk_i);
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      tick(1);
      for (int i = 0; i < 900 && busy; i++)
         tick(1);
      chk("source", 8'h00, {7'h00, busy});
      if (busy)
         final_report();
   endtask : pulse
   // the first tick lands on the second hold-off edge when the ratio is 1:2
   function automatic logic [7:0] pre_exp(int k, int p);
      return 8'(k / p - (p == 2 ? 1 : 0));
   endfunction : pre_exp
   function automatic logic [7:0] ev_exp(logic s, logic e, int k);
      return 8'(s == e ? (k + 1) / 2 : k / 2);
   endfunction : ev_exp
   initial
   begin
      m = $urandom(93773);
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rdchk(CTL, "control", {2'b00, ebt_pkg::RST_CONTROL});
      wr(4'hF, 8'hA5);
      rdchk(4'hF, "unmapped", 8'h00);
      wr(CTL, 8'h08);
      d = 8'($urandom);
      wr(CNT, d);
      rdchk(CNT, "held", d);
      rdchk(CNT, "free", d + 8'h01);
      for (int p = 0; p < 8; p++)
      begin
         wr(CTL, 8'(p));
         wr(CNT, 8'h00);
         m = (3 << (p + 1)) + $urandom % (2 << p);
         tick(m);
         chk("prescaled", pre_exp(m, 2 << p), count_o);
      end
      for (int e = 0; e < 4; e++)
      begin
         wr(CTL, {3'b001, e[0], 4'h8});
         tick(4);
         wr(CNT, 8'h00);
         n <= 6'($urandom_range(40, 1));
         gap <= 3'($urandom);
         d = {7'h00, ext};
         pulse();
         tick(6);
         chk("events", ev_exp(d[0], e[0], n), count_o);
      end
      wr(CTL, 8'h08);
      wr(MSK, 8'h01);
      wr(CNT, 8'hFD);
      for (int i = 0; i < 20 && irq_o !== 1'b1; i++)
         tick(1);
      chk("irq", 8'h01, {7'h00, irq_o});
      if (irq_o !== 1'b1)
         final_report();
      wr(STS, 8'h00);
      rdchk(STS, "kept", 8'h01);
      wr(STS, 8'h01);
      rdchk(STS, "cleared", 8'h00);
      wr(MSK, 8'h00);
      wr(CNT, 8'hFF);
      tick(3);
      chk("gate", 8'h01, {7'h00, gate_source_o});
      tick(1);
      chk("gate end", 8'h00, {7'h00, gate_source_o});
      tick(2);
      chk("masked", 8'h00, {7'h00, irq_o});
      rdchk(STS, "silent", 8'h01);
      final_report();
   end
endmodule : ebt_timer_test
`default_nettype wire
